// ==== rate_trim_and_calibration.sv ====
// Purpose: clock trim resampler pacing plus offset and gain calibration control
// Assumes: filter samples arrive as one-cycle strobes far apart (over 40 clocks)
// Notes: byte register port; trim bytes take effect at the end of a write frame
// Overview of operation
// - trim range 244 ppm, step one in 2^27
// - trim is signed; positive slows data rate
// - trim 8000h turns resampler fully off
// - trim 0000h passes data, adds eight clocks
// - both trim bytes load into resampler together
// - subtract offset, multiply by gain/400000h
// - clip corrected result to 32 bits
// - highpass enabled bypasses offset subtraction
// - offset seeds highpass accumulator when enabled
// - offset 24 bits, three bytes, left-justified
// - offset is two's complement
// - gain 24-bit unsigned, 400000h is unity
// - zero cal ends after 81 periods, offset applied
// - scale cal computes gain, ends after 81
// - continuous sync barred while resampler enabled
// - resampler enable change loses synchronization
// - highpass active when filter select is 11b
// - only disable-enable reloads offset into highpass
`timescale 1ns/1ps
`include "rate_trim_consts.svh"
module rate_trim_and_calibration
	import rate_trim_pkg::*;
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        nrst,
	// register port
	input  wire logic        regWrite,
	input  wire logic [3:0]  regAddr,
	input  wire logic [7:0]  regWdata,
	input  wire logic        regFrameEnd,
	output logic      [7:0]  regRdata,
	// commands and mode
	input  wire logic        zeroCalCommand,
	input  wire logic        scaleCalCommand,
	input  wire logic [1:0]  filterSelect,
	input  wire logic        readStart,
	// filter sample stream
	input  wire logic [31:0] filterData,
	input  wire logic        filterValid,
	// outputs
	output logic      [31:0] sampleData,
	output logic             sampleValidN,
	output logic             resamplerEnabled,
	output logic             contSyncAllowed,
	output logic             syncLost,
	output logic             highpassSeedLoad,
	output logic      [23:0] highpassSeed
);
	cal_bus_if bus ();
	cal_datapath u_dp (.clock(clock), .nrst(nrst), .bus(bus));

	logic [7:0]  trimLow;
	logic [7:0]  trimHigh;
	logic [15:0] trimActive;
	word24_t     offsetCorr;
	word24_t     gainCorr;
	logic [26:0] phaseAcc;
	logic [31:0] heldData;
	logic [4:0]  delayCnt;
	logic        delayBusy;
	logic        hpPrev;
	logic [3:0]  drdyCnt;
	cal_state_t  calState;
	logic [6:0]  calCnt;
	logic [4:0]  divStep;
	word24_t     quot;
	logic [31:0] divisor;
	logic        calDone;
	logic [7:0]  next_trimLow, next_trimHigh, next_regRdata;
	logic [15:0] next_trimActive;
	word24_t     next_offsetCorr, next_gainCorr, next_quot, trial;
	logic [26:0] next_phaseAcc;
	logic [27:0] accSum;
	logic [31:0] next_heldData, next_divisor, next_sampleData;
	logic [4:0]  next_delayCnt, next_divStep;
	logic        next_delayBusy, next_hpPrev, next_sampleValidN, next_syncLost;
	logic        next_highpassSeedLoad, next_calDone;
	logic [3:0]  next_drdyCnt;
	cal_state_t  next_calState;
	logic [6:0]  next_calCnt;
	logic        hpOn, trimEnabled, launch;
	logic signed [32:0] corrected;
	logic [57:0] trialProd;

	function automatic logic isEnabled(input logic [15:0] t);
		isEnabled = (t != `TRIM_DISABLE);
	endfunction

	always_comb
	begin
		hpOn = (filterSelect == `FILTER_HPF);
		trimEnabled = isEnabled(trimActive);
		next_trimLow = trimLow;
		next_trimHigh = trimHigh;
		next_offsetCorr = offsetCorr;
		next_gainCorr = gainCorr;
		if (regWrite)
		begin
			if (regAddr == `ADDR_TRIM_LO)
				next_trimLow = regWdata;
			else if (regAddr == `ADDR_TRIM_HI)
				next_trimHigh = regWdata;
			else if (regAddr == `ADDR_OFS_LO)
				next_offsetCorr[7:0] = regWdata;
			else if (regAddr == `ADDR_OFS_MID)
				next_offsetCorr[15:8] = regWdata;
			else if (regAddr == `ADDR_OFS_HI)
				next_offsetCorr[23:16] = regWdata;
			else if (regAddr == `ADDR_GAIN_LO)
				next_gainCorr[7:0] = regWdata;
			else if (regAddr == `ADDR_GAIN_MID)
				next_gainCorr[15:8] = regWdata;
			else if (regAddr == `ADDR_GAIN_HI)
				next_gainCorr[23:16] = regWdata;
		end
		// staged bytes move as one word so a half-written trim is never used
		next_trimActive = regFrameEnd ? {trimHigh, trimLow} : trimActive;
		next_syncLost = isEnabled(next_trimActive) != trimEnabled;
		if (regAddr == `ADDR_TRIM_LO)
			next_regRdata = trimLow;
		else if (regAddr == `ADDR_TRIM_HI)
			next_regRdata = trimHigh;
		else if (regAddr == `ADDR_OFS_LO)
			next_regRdata = offsetCorr[7:0];
		else if (regAddr == `ADDR_OFS_MID)
			next_regRdata = offsetCorr[15:8];
		else if (regAddr == `ADDR_OFS_HI)
			next_regRdata = offsetCorr[23:16];
		else if (regAddr == `ADDR_GAIN_LO)
			next_regRdata = gainCorr[7:0];
		else if (regAddr == `ADDR_GAIN_MID)
			next_regRdata = gainCorr[15:8];
		else if (regAddr == `ADDR_GAIN_HI)
			next_regRdata = gainCorr[23:16];
		else
			next_regRdata = 8'h00;

		// seed only on the off-to-on edge; later offset writes never reach it
		next_hpPrev = hpOn;
		next_highpassSeedLoad = hpOn && !hpPrev;

		// resampler pacing: the signed trim accumulates in 2^-27 steps of a period
		accSum = {1'b0, phaseAcc} + {{12{trimActive[15]}}, trimActive};
		next_phaseAcc = phaseAcc;
		next_heldData = heldData;
		next_delayBusy = delayBusy;
		next_delayCnt = delayCnt;
		launch = 1'b0;
		if (filterValid)
		begin
			// launch a clock after capture so the datapath reads the new sample
			next_heldData = filterData;
			next_delayBusy = 1'b1;
			next_delayCnt = `LAUNCH_CLKS;
			if (trimEnabled)
			begin
				next_phaseAcc = accSum[26:0];
				next_delayCnt = `LAUNCH_CLKS + `PASS_DELAY_CLKS;
				// carry stretches this period by one clock, borrow shortens it
				if (accSum[27] && !trimActive[15])
					next_delayCnt = `LAUNCH_CLKS + `PASS_DELAY_CLKS + 5'h01;
				else if (accSum[27] && trimActive[15])
					next_delayCnt = `LAUNCH_CLKS + `PASS_DELAY_CLKS - 5'h01;
			end
		end
		else if (delayBusy)
		begin
			next_delayCnt = delayCnt - 5'h01;
			if (delayCnt == 5'h01)
			begin
				launch = 1'b1;
				next_delayBusy = 1'b0;
			end
		end

		corrected = $signed({heldData[31], heldData}) - $signed({offsetCorr[23], offsetCorr, 8'h00});
		trial = quot | (`GAIN_UNITY >> `GAIN_SHIFT << divStep[4:0]);
		trialProd = {26'h0, divisor} * {34'h0, trial};
		next_calState = calState;
		next_calCnt = calCnt;
		next_divStep = divStep;
		next_quot = quot;
		next_divisor = divisor;
		next_calDone = 1'b0;
		case (calState)
			CAL_IDLE:
			begin
				next_calCnt = 7'h00;
				if (zeroCalCommand)
					next_calState = CAL_ZERO;
				else if (scaleCalCommand)
					next_calState = CAL_SCALE;
			end
			CAL_ZERO:
			begin
				if (launch)
					next_calCnt = calCnt + 7'h01;
				if (launch && calCnt == `CAL_PERIODS - 7'h01)
				begin
					next_offsetCorr = heldData[31:8];
					next_calDone = 1'b1;
					next_calState = CAL_IDLE;
				end
			end
			CAL_SCALE:
			begin
				if (launch)
					next_calCnt = calCnt + 7'h01;
				if (launch && calCnt == `CAL_PERIODS - 7'h01)
				begin
					next_divisor = corrected[31:0];
					next_quot = 24'h00_0000;
					next_divStep = `DIV_STEPS - 5'h01;
					next_calState = CAL_DIVIDE;
					if (corrected[32] || corrected == 33'h0_0000_0000)
					begin
						next_gainCorr = `GAIN_MAX;
						next_calDone = 1'b1;
						next_calState = CAL_IDLE;
					end
				end
			end
			CAL_DIVIDE:
			begin
				// bit-serial search for gain = 2^53 / corrected, one bit per clock
				if (trialProd <= `FULL_SCALE_NUM)
					next_quot = trial;
				next_divStep = divStep - 5'h01;
				if (divStep == 5'h00)
				begin
					next_gainCorr = (trialProd <= `FULL_SCALE_NUM) ? trial : quot;
					next_calDone = 1'b1;
					next_calState = CAL_IDLE;
				end
			end
			default:
				next_calState = CAL_IDLE;
		endcase

		// data-ready: high on read or on a fresh sample, low eight clocks after that sample
		next_sampleData = bus.validOut ? bus.dataOut : sampleData;
		next_drdyCnt = (drdyCnt != 4'h0) ? drdyCnt - 4'h1 : 4'h0;
		next_sampleValidN = sampleValidN;
		if (readStart)
			next_sampleValidN = 1'b1;
		// every sample raises ready; only samples outside a calibration rearm the fall
		if (bus.validOut)
		begin
			next_sampleValidN = 1'b1;
			next_drdyCnt = (calState == CAL_IDLE) ? `SAMPLE_VALID_N_HIGH_CLKS : 4'h0;
		end
		else if (drdyCnt == 4'h1)
			next_sampleValidN = 1'b0;
	end

	// calibration result is applied to the sample that ends the calibration
	assign bus.dataIn = heldData;
	assign bus.validIn = launch || calDone;
	assign bus.offset = offsetCorr;
	assign bus.gain = gainCorr;
	assign bus.bypassOffset = hpOn;
	assign resamplerEnabled = trimEnabled;
	assign contSyncAllowed = !trimEnabled;
	assign highpassSeed = offsetCorr;

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			trimLow <= `TRIM_RESET_LO;
			trimHigh <= `TRIM_RESET_HI;
			trimActive <= `TRIM_RESET;
			offsetCorr <= `OFFSET_RESET;
			gainCorr <= `GAIN_UNITY;
			regRdata <= 8'h00;
			phaseAcc <= 27'h000_0000;
			heldData <= 32'h0000_0000;
			delayCnt <= 5'h00;
			delayBusy <= 1'b0;
			hpPrev <= 1'b0;
			highpassSeedLoad <= 1'b0;
			syncLost <= 1'b0;
			calState <= CAL_IDLE;
			calCnt <= 7'h00;
			divStep <= 5'h00;
			quot <= 24'h00_0000;
			divisor <= 32'h0000_0000;
			calDone <= 1'b0;
			sampleData <= 32'h0000_0000;
			sampleValidN <= 1'b1;
			drdyCnt <= 4'h0;
		end
		else
		begin
			trimLow <= next_trimLow;
			trimHigh <= next_trimHigh;
			trimActive <= next_trimActive;
			offsetCorr <= next_offsetCorr;
			gainCorr <= next_gainCorr;
			regRdata <= next_regRdata;
			phaseAcc <= next_phaseAcc;
			heldData <= next_heldData;
			delayCnt <= next_delayCnt;
			delayBusy <= next_delayBusy;
			hpPrev <= next_hpPrev;
			highpassSeedLoad <= next_highpassSeedLoad;
			syncLost <= next_syncLost;
			calState <= next_calState;
			calCnt <= next_calCnt;
			divStep <= next_divStep;
			quot <= next_quot;
			divisor <= next_divisor;
			calDone <= next_calDone;
			sampleData <= next_sampleData;
			sampleValidN <= next_sampleValidN;
			drdyCnt <= next_drdyCnt;
		end
	end
endmodule

// ==== rate_trim_consts.svh ====
// Purpose: named constants for the rate trim and calibration block
// Assumes: 25 MHz master clock, byte-wide register port
// Notes: register addresses are local indices of the byte register port
`ifndef RATE_TRIM_CONSTS_SVH
`define RATE_TRIM_CONSTS_SVH
`define ADDR_TRIM_LO    4'h0
`define ADDR_TRIM_HI    4'h1
`define ADDR_OFS_LO     4'h2
`define ADDR_OFS_MID    4'h3
`define ADDR_OFS_HI     4'h4
`define ADDR_GAIN_LO    4'h5
`define ADDR_GAIN_MID   4'h6
`define ADDR_GAIN_HI    4'h7
`define TRIM_DISABLE    16'h8000
`define TRIM_PASS       16'h0000
`define TRIM_RESET      16'h8000
`define TRIM_RESET_LO   8'h00
`define TRIM_RESET_HI   8'h80
`define OFFSET_RESET    24'h00_0000
`define GAIN_UNITY      24'h40_0000
`define GAIN_MAX        24'hFF_FFFF
`define GAIN_SHIFT      22
`define FRAC_BITS       27
`define PASS_DELAY_CLKS 5'h08
`define LAUNCH_CLKS     5'h01
`define SAMPLE_VALID_N_HIGH_CLKS  4'h8
`define CAL_PERIODS     7'h51
`define DIV_STEPS       5'h18
`define FULL_SCALE_NUM  58'h020_0000_0000_0000
`define FILTER_HPF      2'h3
`define SAT_POS         32'h7FFF_FFFF
`define SAT_NEG         32'h8000_0000
`define HOST_LEAD_CLKS  9'h100
`endif

// ==== rate_trim_pkg.sv ====
// Purpose: shared types of the rate trim and calibration block
// Assumes: nothing beyond the constants header
// Notes: types only
package rate_trim_pkg;
	typedef enum logic [1:0] {CAL_IDLE, CAL_ZERO, CAL_SCALE, CAL_DIVIDE} cal_state_t;
	typedef logic [23:0] word24_t;
endpackage

// ==== cal_bus_if.sv ====
// Purpose: carrier between the control top and the calibration datapath
// Assumes: single clock domain
// Notes: dataOut and validOut are registered in the datapath
`timescale 1ns/1ps
interface cal_bus_if;
	logic [31:0] dataIn;
	logic        validIn;
	logic [23:0] offset;
	logic [23:0] gain;
	logic        bypassOffset;
	logic [31:0] dataOut;
	logic        validOut;
	modport ctrl (output dataIn, validIn, offset, gain, bypassOffset, input dataOut, validOut);
	modport dp   (input dataIn, validIn, offset, gain, bypassOffset, output dataOut, validOut);
endinterface

// ==== cal_datapath.sv ====
// Purpose: offset subtract, gain multiply, clip to 32 bits
// Assumes: one sample at a time, one cycle latency
// Notes: full-width product avoids intermediate wrap before clipping
`timescale 1ns/1ps
`include "rate_trim_consts.svh"
module cal_datapath
	import rate_trim_pkg::*;
(
	// clock and reset
	input  wire logic clock,
	input  wire logic nrst,
	// datapath carrier
	cal_bus_if.dp     bus
);
	logic signed [32:0] diff;
	logic signed [57:0] prod;
	logic signed [57:0] scaled;
	logic        [31:0] next_dataOut;
	logic               next_validOut;
	logic        [31:0] dataOut;
	logic               validOut;

	always_comb
	begin
		if (bus.bypassOffset)
			diff = $signed({bus.dataIn[31], bus.dataIn});
		else
			diff = $signed({bus.dataIn[31], bus.dataIn})
				- $signed({bus.offset[23], bus.offset, 8'h00});
		prod = 58'(diff) * $signed({34'h0, bus.gain});
		scaled = prod >>> `GAIN_SHIFT;
		if (scaled > $signed({26'h0, `SAT_POS}))
			next_dataOut = `SAT_POS;
		else if (scaled < $signed({26'h3FF_FFFF, `SAT_NEG}))
			next_dataOut = `SAT_NEG;
		else
			next_dataOut = scaled[31:0];
		next_validOut = bus.validIn;
		if (!bus.validIn)
			next_dataOut = dataOut;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			dataOut  <= 32'h0000_0000;
			validOut <= 1'b0;
		end
		else
		begin
			dataOut  <= next_dataOut;
			validOut <= next_validOut;
		end
	end

	assign bus.dataOut  = dataOut;
	assign bus.validOut = validOut;
endmodule

// ==== rate_trim_monitor.sv ====
// Purpose: port checker for rate trim and calibration
// Assumes: single clock domain, async active-low reset
// Notes: bound to the top module below
`timescale 1ns/1ps
module rate_trim_monitor
(
	// clock and reset
	input wire logic        clock,
	input wire logic        nrst,
	// watched ports
	input wire logic        regFrameEnd,
	input wire logic [1:0]  filterSelect,
	input wire logic        filterValid,
	input wire logic        sampleValidN,
	input wire logic        resamplerEnabled,
	input wire logic        contSyncAllowed,
	input wire logic        syncLost,
	input wire logic        highpassSeedLoad,
	input wire logic [23:0] highpassSeed
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	property p_sync_mode;
		contSyncAllowed == !resamplerEnabled;
	endproperty
	a_sync_mode: assert property (p_sync_mode) else $error("sync mode permit wrong");
	property p_lose_sync;
		$changed(resamplerEnabled) |-> syncLost;
	endproperty
	a_lose_sync: assert property (p_lose_sync) else $error("no sync loss");
	property p_lose_cause;
		syncLost |-> $changed(resamplerEnabled);
	endproperty
	a_lose_cause: assert property (p_lose_cause) else $error("stray sync loss");
	property p_trim_frame;
		$changed(resamplerEnabled) |-> $past(regFrameEnd);
	endproperty
	a_trim_frame: assert property (p_trim_frame) else $error("trim outside frame");
	property p_seed_load;
		$rose(filterSelect == 2'h3) |=> highpassSeedLoad;
	endproperty
	a_seed_load: assert property (p_seed_load) else $error("seed not loaded");
	property p_seed_cause;
		highpassSeedLoad |-> $past(filterSelect) == 2'h3;
	endproperty
	a_seed_cause: assert property (p_seed_cause) else $error("seed load unasked");
	property p_seed_pulse;
		highpassSeedLoad |=> !highpassSeedLoad;
	endproperty
	a_seed_pulse: assert property (p_seed_pulse) else $error("seed load too long");
	// four edges on is past the launch under either reading of the walk
	property p_bypass_sample_valid_n;
		filterValid && !resamplerEnabled |-> ##4 sampleValidN;
	endproperty
	a_bypass_sample_valid_n: assert property (p_bypass_sample_valid_n) else $error("ready early");
	property p_seed_reset;
		!$past(nrst) |-> highpassSeed == 24'h00_0000;
	endproperty
	a_seed_reset: assert property (p_seed_reset) else $error("offset not reset");
endmodule

bind rate_trim_and_calibration rate_trim_monitor i_rate_trim_monitor
(
	.clock(clock), .nrst(nrst), .regFrameEnd(regFrameEnd), .filterSelect(filterSelect),
	.filterValid(filterValid), .sampleValidN(sampleValidN),
	.resamplerEnabled(resamplerEnabled), .contSyncAllowed(contSyncAllowed),
	.syncLost(syncLost), .highpassSeedLoad(highpassSeedLoad), .highpassSeed(highpassSeed)
);

// ==== host_model.sv ====
// Purpose: host controller on the byte register port
// Assumes: requests launched just after a rising edge
// Notes: the trim task sends both trim bytes in one frame
`timescale 1ns/1ps
module host_model
(
	// clock
	input  wire logic       clock,
	// register port
	output logic            regWrite = 1'b0,
	output logic      [3:0] regAddr = 4'h0,
	output logic      [7:0] regWdata = 8'h00,
	output logic            regFrameEnd = 1'b0,
	input  wire logic [7:0] regRdata
);
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
	begin
		@(posedge clock);
		regWrite <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge clock);
		regWrite <= 1'b0;
	end
	endtask
	task automatic wr24(input logic [3:0] a, input logic [23:0] v);
	begin
		for (int k = 0; k < 3; k++)
			wr(a + 4'(k), v[8*k +: 8]);
	end
	endtask
	// both bytes in one frame, long before any ready edge
	task automatic trim(input logic [15:0] t);
	begin
		wr(4'h1, t[15:8]);
		wr(4'h0, t[7:0]);
		@(posedge clock);
		regFrameEnd <= 1'b1;
		@(posedge clock);
		regFrameEnd <= 1'b0;
	end
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] r);
	begin
		@(posedge clock);
		regAddr <= a;
		repeat (2) @(posedge clock);
		@(negedge clock);
		r = regRdata;
	end
	endtask
endmodule

// ==== rate_trim_and_calibration_tb_top.sv ====
// Purpose: self-checking bench for rate trim and calibration
// Assumes: host model owns the register port
// Notes: trim delay judged against a disabled baseline
`timescale 1ns/1ps
module rate_trim_and_calibration_tb_top;
	logic        clock = 1'b0;
	logic        nrst = 1'b0;
	logic        zeroCalCommand = 1'b0;
	logic        scaleCalCommand = 1'b0;
	logic        filterValid = 1'b0;
	logic [1:0]  filterSelect = 2'h0;
	logic [31:0] filterData = 32'h0000_0000;
	logic [31:0] rnd = 32'h0000_0048;
	logic        regWrite, regFrameEnd, sampleValidN, resamplerEnabled, syncLost;
	logic [3:0]  regAddr;
	logic [7:0]  regWdata, regRdata, b;
	logic [23:0] o, g, v;
	logic [31:0] sampleData, d;
	logic [79:0] tbl [4];
	int          miscompares = 0;
	int          samplesChecked = 0;
	int          falls = 0;
	int          n, n0;
	int          resyncs = 0;

	host_model i_host_model
	(
		.clock(clock), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
		.regFrameEnd(regFrameEnd), .regRdata(regRdata)
	);
	// read strobe tied low: ready is judged by its own falling edges
	rate_trim_and_calibration i_rate_trim_and_calibration
	(
		.clock(clock), .nrst(nrst), .regWrite(regWrite), .regAddr(regAddr),
		.regWdata(regWdata), .regFrameEnd(regFrameEnd), .regRdata(regRdata),
		.zeroCalCommand(zeroCalCommand), .scaleCalCommand(scaleCalCommand),
		.filterSelect(filterSelect), .readStart(1'b0), .filterData(filterData),
		.filterValid(filterValid), .sampleData(sampleData), .sampleValidN(sampleValidN),
		.resamplerEnabled(resamplerEnabled), .contSyncAllowed(), .syncLost(syncLost),
		.highpassSeedLoad(), .highpassSeed()
	);

	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] cal(input logic [31:0] x, input logic [23:0] ov, gv,
		input logic hp);
		longint p;
	begin
		p = longint'($signed(x));
		if (!hp)
			p = p - longint'($signed({ov, 8'h00}));
		p = (p * longint'({1'b0, gv})) >>> 22;
		if (p > longint'(32'sh7FFF_FFFF))
			return 32'h7FFF_FFFF;
		if (p < longint'(32'sh8000_0000))
			return 32'h8000_0000;
		return p[31:0];
	end
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, exp);
	begin
		samplesChecked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	end
	endtask
	task automatic stop_test;
	begin
		$display("checks %0d mismatches %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask
	// k counts negedges until ready falls; bounded since calibration holds it high
	task automatic smp(input logic [31:0] x, output int k);
		int f;
	begin
		@(posedge clock);
		filterValid <= 1'b1;
		filterData  <= x;
		@(posedge clock);
		filterValid <= 1'b0;
		f = falls;
		k = 1;
		while (falls == f && k < 80)
		begin
			@(negedge clock);
			k++;
		end
		repeat (40) @(posedge clock);
	end
	endtask
	task automatic rd24(input logic [3:0] a, output logic [23:0] w);
		logic [7:0] r;
	begin
		for (int k = 0; k < 3; k++)
		begin
			i_host_model.rd(a + 4'(k), r);
			w[8*k +: 8] = r;
		end
	end
	endtask
	task automatic calRun(input logic z, input logic [31:0] x);
		int f;
	begin
		@(posedge clock);
		zeroCalCommand  <= z;
		scaleCalCommand <= !z;
		@(posedge clock);
		zeroCalCommand  <= 1'b0;
		scaleCalCommand <= 1'b0;
		f = falls;
		repeat (80) smp(x, n);
		chk("cal quiet", 32'(falls - f), 32'h0000_0000);
		smp(x, n);
		chk("cal done", 32'(falls - f), 32'h0000_0001);
	end
	endtask

	initial
		forever #20 clock = ~clock;
	always @(negedge sampleValidN)
		falls++;
	// bench counts every clock with syncLost high as one resync
	always @(negedge clock)
		if (syncLost)
			resyncs++;
	initial
	begin
		#2_400_000;
		miscompares++;
		stop_test();
	end

	initial
	begin
		tbl[0] = {32'h0000_0000, 24'h00_007F, 24'h40_0000};
		tbl[1] = {32'h0000_0000, 24'h80_0000, 24'h40_0000};
		tbl[2] = {32'h7FFF_0000, 24'h00_0000, 24'hFF_FFFF};
		tbl[3] = {32'h8000_0000, 24'h00_0000, 24'hFF_FFFF};
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		for (int i = 0; i < 9; i++)
		begin
			i_host_model.rd(4'(i), b);
			d = (i == 1) ? 32'h0000_0080 : (i == 7) ? 32'h0000_0040 : 32'h0000_0000;
			chk("reset reg", 32'(b), d);
		end
		$display("test reset done");
		smp(32'h0000_1234, n0);
		chk("plain data", sampleData, 32'h0000_1234);
		i_host_model.wr(4'h1, 8'h00);
		repeat (2) @(negedge clock);
		chk("half trim", 32'(resamplerEnabled), 32'h0000_0000);
		i_host_model.trim(16'h0000);
		@(negedge clock);
		chk("enable", 32'(resamplerEnabled), 32'h0000_0001);
		smp(32'h0000_1234, n);
		chk("pass delay", 32'(n - n0), 32'h0000_0008);
		chk("pass data", sampleData, 32'h0000_1234);
		chk("resync on", 32'(resyncs), 32'h0000_0001);
		i_host_model.trim(16'h8000);
		@(negedge clock);
		chk("disable", 32'(resamplerEnabled), 32'h0000_0000);
		@(negedge clock);
		chk("resync off", 32'(resyncs), 32'h0000_0002);
		$display("test trim done");
		for (int i = 0; i < 10; i++)
		begin
			if (i < 4)
				{d, o, g} = tbl[i];
			else
			begin
				repeat (8) rnd = step(rnd);
				// small corrections keep the host inside its calibrated range
				o = {{8{rnd[15]}}, rnd[15:0]};
				repeat (8) rnd = step(rnd);
				g = {8'h40, rnd[15:0]};
				repeat (8) rnd = step(rnd);
				d = rnd;
			end
			i_host_model.wr24(4'h2, o);
			i_host_model.wr24(4'h5, g);
			smp(d, n);
			chk("corrected", sampleData, cal(d, o, g, 1'b0));
		end
		@(posedge clock);
		filterSelect <= 2'h3;
		smp(d, n);
		chk("highpass", sampleData, cal(d, o, g, 1'b1));
		@(posedge clock);
		filterSelect <= 2'h0;
		$display("test datapath done");
		i_host_model.wr24(4'h2, 24'h00_0000);
		i_host_model.wr24(4'h5, 24'h40_0000);
		repeat (8) rnd = step(rnd);
		d = rnd;
		repeat (64) smp(d, n);
		i_host_model.wr24(4'h2, d[31:8]);
		smp(d, n);
		chk("manual cal", sampleData, cal(d, d[31:8], 24'h40_0000, 1'b0));
		i_host_model.wr24(4'h2, 24'h00_0000);
		calRun(1'b1, 32'h0012_3456);
		chk("zero cal data", sampleData, 32'h0000_0056);
		rd24(4'h2, v);
		chk("zero cal offset", 32'(v), 32'h0000_1234);
		i_host_model.wr24(4'h2, 24'h00_0000);
		calRun(1'b0, 32'h4000_0000);
		chk("scale cal data", sampleData, 32'h7FFF_FFFF);
		rd24(4'h5, v);
		chk("scale cal gain", 32'(v), 32'h0080_0000);
		$display("test calibration done");
		stop_test();
	end
endmodule
